// ==== rpcb_regs.svh ====
`ifndef RPCB_REGS_SVH
`define RPCB_REGS_SVH

// register byte addresses on the configuration port
`define RPCB_CAP_LO_ADDR   32'h4000_0000
`define RPCB_CAP_HI_ADDR   32'h4000_0004

// value read from an unmapped address or outside the read cycle
`define RPCB_RDATA_IDLE    32'h0000_0000

// reserved upper bits of both capture registers read as zero
`define RPCB_RSVD_ZERO     24'h00_0000

// hardware boot address: internal rom, lowest address
`define RPCB_BOOT_ADDR     32'h0000_0000

// width of one capture field group
`define RPCB_CAP_W         8

// reset value of the capture bits
`define RPCB_CAP_RST       8'h00

// capture register low: bit positions
`define RPCB_LO_SPI0_OUT   7
`define RPCB_LO_SPI0_IN    6
`define RPCB_LO_SPI0_CLOCK 5
`define RPCB_LO_SPI0_CS    4
`define RPCB_LO_SPI0_EN    3
`define RPCB_LO_SPI1_SOMI  2
`define RPCB_LO_SPI1_SIMO  1
`define RPCB_LO_SPI1_CLK   0

// capture register high: bit positions
`define RPCB_HI_SPI1_CS    7
`define RPCB_HI_SPI1_EN    6
`define RPCB_HI_HOST_CS    5
`define RPCB_HI_HOST_D0    4
`define RPCB_HI_EMIF_D16   3
`define RPCB_HI_TX_FS      2
`define RPCB_HI_RX_FS      1
`define RPCB_HI_SER_D0     0

`endif

// ==== rpcb_pkg.sv ====
package rpcb_pkg;

  // the sixteen strapped pins, sampled on the core clock
  typedef struct packed {
    logic spi0_slave_out;
    logic spi0_slave_in;
    logic spi0_clock;
    logic spi0_chip_select;
    logic spi0_enable_pin;
    logic spi1_slave_out;
    logic spi1_slave_in;
    logic spi1_clock;
    logic spi1_chip_select;
    logic spi1_enable_pin;
    logic host_chip_select;
    logic host_data0;
    logic emif_d16_host_a0;
    logic audio_tx_frame_sync;
    logic audio_rx_frame_sync;
    logic audio_serializer_data;
  } rpcb_pins_s;

  // register port request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rpcb_bus_req_s;

  // host-port configuration copied from the straps
  typedef struct packed {
    logic host_byte_address_bit;
    logic host_full_width_bit;
    logic host_nonmultiplexed_bit;
  } rpcb_hpi_cfg_s;

  // core boot sequencing
  typedef enum logic [0:0] {
    RPCB_HELD,
    RPCB_RUN
  } rpcb_boot_e;

  // state of the edge detector
  typedef struct packed {
    logic prev;
  } rpcb_edge_state_s;

  // state of one capture register
  typedef struct packed {
    logic [7:0] bits;
  } rpcb_cap_state_s;

  // state of the top block
  typedef struct packed {
    rpcb_boot_e    fsm;
    logic          start;
    logic [31:0]   pc;
    rpcb_hpi_cfg_s hpi;
    logic [31:0]   rdata;
  } rpcb_top_state_s;

endpackage : rpcb_pkg

// ==== rpcb_edge_det.sv ====
`timescale 1ns/10ps
`include "rpcb_regs.svh"

module rpcb_edge_det (
  input  wire logic core_clk_i,  // core clock
  input  wire logic reset_i,     // synchronous reset, active high
  input  wire logic pin_i,       // level to watch
  output logic      rise_o       // one-cycle pulse on a low-to-high step
);

  rpcb_pkg::rpcb_edge_state_s st_q;  // registered state
  rpcb_pkg::rpcb_edge_state_s st_d;  // next state

  // remember the previous level; during reset treat it as low
  always_comb begin
    st_d      = st_q;
    st_d.prev = pin_i;
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_q.prev <= 1'h0;
    end else begin
      st_q <= st_d;
    end
  end

  // a release of the pin shows as a rise; none while in reset
  assign rise_o = pin_i & ~st_q.prev & ~reset_i;

endmodule : rpcb_edge_det

// ==== rpcb_cap_reg.sv ====
`timescale 1ns/10ps
`include "rpcb_regs.svh"

module rpcb_cap_reg (
  input  wire logic                    core_clk_i,  // core clock
  input  wire logic                    reset_i,     // synchronous reset
  input  wire logic                    load_i,      // capture strobe
  input  wire logic [`RPCB_CAP_W-1:0]  d_i,         // pin levels
  output logic      [`RPCB_CAP_W-1:0]  q_o          // captured levels
);

  rpcb_pkg::rpcb_cap_state_s st_q;                  // registered state
  rpcb_pkg::rpcb_cap_state_s st_d;                  // next state
  logic [`RPCB_CAP_W-1:0]    nxt;                   // per-bit next value

  // each bit reloads only on the strobe, else it holds
  for (genvar i = 0; i < `RPCB_CAP_W; i++) begin : g_bit
    assign nxt[i] = load_i ? d_i[i] : st_q.bits[i];
  end

  // next state
  always_comb begin
    st_d      = st_q;
    st_d.bits = nxt;
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_q.bits <= `RPCB_CAP_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign q_o = st_q.bits;

endmodule : rpcb_cap_reg

// ==== rpcb_top.sv ====
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`include "rpcb_regs.svh"

module rpcb_top (
  input  wire logic                   core_clk_i,     // core clock, 250 MHz
  input  wire logic                   reset_i,        // synchronous reset
  input  wire logic                   ext_reset_n_i,  // external reset pin
  input  wire logic                   emu_reset_i,    // emulator reset
  input  wire logic                   wdt_reset_i,    // watchdog reset
  input  wire rpcb_pkg::rpcb_pins_s   pins_i,         // strapped pins
  input  wire rpcb_pkg::rpcb_bus_req_s reg_req_i,     // register request
  output logic [31:0]                 reg_rdata_o,    // read data
  output logic [31:0]                 boot_pc_o,      // core start address
  output logic                        cpu_start_o,    // core release pulse
  output rpcb_pkg::rpcb_hpi_cfg_s     host_cfg_o,     // host-port config
  output logic [`RPCB_CAP_W-1:0]      cap_lo_o,       // capture low
  output logic [`RPCB_CAP_W-1:0]      cap_hi_o        // capture high
);

  //////////////////////////////////////////////////////////////////////////
  // declarations
  //////////////////////////////////////////////////////////////////////////

  rpcb_pkg::rpcb_top_state_s st_q;              // registered state
  rpcb_pkg::rpcb_top_state_s st_d;              // next state
  logic                      cap_load;          // pin release seen
  logic                      in_reset;          // any reset source active
  logic [`RPCB_CAP_W-1:0]    lo_pins;           // pins for capture low
  logic [`RPCB_CAP_W-1:0]    hi_pins;           // pins for capture high
  logic [`RPCB_CAP_W-1:0]    cap_lo;            // capture low contents
  logic [`RPCB_CAP_W-1:0]    cap_hi;            // capture high contents
  logic                      hit_lo;            // address hits low reg
  logic                      hit_hi;            // address hits high reg

  //////////////////////////////////////////////////////////////////////////
  // capture trigger
  //////////////////////////////////////////////////////////////////////////

  // the rising edge of the external pin is the only capture trigger;
  // emulator and watchdog resets are not wired here on purpose
  rpcb_edge_det u_edge (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .pin_i      (ext_reset_n_i),
    .rise_o     (cap_load)
  );

  //////////////////////////////////////////////////////////////////////////
  // pin routing into the two capture groups
  //////////////////////////////////////////////////////////////////////////

  // spread the strapped pins onto their bit positions
  always_comb begin
    lo_pins = `RPCB_CAP_RST;
    hi_pins = `RPCB_CAP_RST;
    lo_pins[`RPCB_LO_SPI0_OUT]   = pins_i.spi0_slave_out;
    lo_pins[`RPCB_LO_SPI0_IN]    = pins_i.spi0_slave_in;
    lo_pins[`RPCB_LO_SPI0_CLOCK] = pins_i.spi0_clock;
    lo_pins[`RPCB_LO_SPI0_CS]   = pins_i.spi0_chip_select;
    lo_pins[`RPCB_LO_SPI0_EN]   = pins_i.spi0_enable_pin;
    lo_pins[`RPCB_LO_SPI1_SOMI] = pins_i.spi1_slave_out;
    lo_pins[`RPCB_LO_SPI1_SIMO] = pins_i.spi1_slave_in;
    lo_pins[`RPCB_LO_SPI1_CLK]  = pins_i.spi1_clock;
    hi_pins[`RPCB_HI_SPI1_CS]   = pins_i.spi1_chip_select;
    hi_pins[`RPCB_HI_SPI1_EN]   = pins_i.spi1_enable_pin;
    hi_pins[`RPCB_HI_HOST_CS]   = pins_i.host_chip_select;
    hi_pins[`RPCB_HI_HOST_D0]   = pins_i.host_data0;
    hi_pins[`RPCB_HI_EMIF_D16]  = pins_i.emif_d16_host_a0;
    hi_pins[`RPCB_HI_TX_FS]     = pins_i.audio_tx_frame_sync;
    hi_pins[`RPCB_HI_RX_FS]     = pins_i.audio_rx_frame_sync;
    hi_pins[`RPCB_HI_SER_D0]    = pins_i.audio_serializer_data;
  end

  // capture register low; no write path reaches it
  rpcb_cap_reg u_cap_lo (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .load_i     (cap_load),
    .d_i        (lo_pins),
    .q_o        (cap_lo)
  );

  // capture register high; no write path reaches it
  rpcb_cap_reg u_cap_hi (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .load_i     (cap_load),
    .d_i        (hi_pins),
    .q_o        (cap_hi)
  );

  //////////////////////////////////////////////////////////////////////////
  // register decode
  //////////////////////////////////////////////////////////////////////////

  // full-address compare, word registers only
  assign hit_lo = (reg_req_i.addr == `RPCB_CAP_LO_ADDR);
  assign hit_hi = (reg_req_i.addr == `RPCB_CAP_HI_ADDR);

  // the core is held while any reset source is active
  assign in_reset = ~ext_reset_n_i | emu_reset_i | wdt_reset_i;

  //////////////////////////////////////////////////////////////////////////
  // next state
  //////////////////////////////////////////////////////////////////////////

  always_comb begin
    st_d       = st_q;
    st_d.start = 1'h0;
    st_d.rdata = `RPCB_RDATA_IDLE;
    // start address is fixed in hardware, nothing can move it
    st_d.pc    = `RPCB_BOOT_ADDR;

    // boot sequencing: release the core once every reset is gone
    case (st_q.fsm)
      rpcb_pkg::RPCB_HELD: begin
        if (!in_reset) begin
          st_d.fsm   = rpcb_pkg::RPCB_RUN;
          st_d.start = 1'h1;
        end
      end
      rpcb_pkg::RPCB_RUN: begin
        if (in_reset) begin
          st_d.fsm = rpcb_pkg::RPCB_HELD;
        end
      end
      default: begin
        st_d.fsm = rpcb_pkg::RPCB_HELD;
      end
    endcase

    // host boot strap: copy the three spi0 levels as host config
    if (cap_load && !pins_i.host_chip_select) begin
      st_d.hpi.host_byte_address_bit   = pins_i.spi0_slave_out;
      st_d.hpi.host_full_width_bit     = pins_i.spi0_slave_in;
      st_d.hpi.host_nonmultiplexed_bit = pins_i.spi0_clock;
    end

    // reads: data in the next cycle, reserved bits as zero
    if (reg_req_i.rd) begin
      if (hit_lo) begin
        st_d.rdata = {`RPCB_RSVD_ZERO, cap_lo};
      end else if (hit_hi) begin
        st_d.rdata = {`RPCB_RSVD_ZERO, cap_hi};
      end else begin
        st_d.rdata = `RPCB_RDATA_IDLE;
      end
    end
    // writes are accepted and dropped: the captures are read-only
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  //////////////////////////////////////////////////////////////////////////

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_q.fsm   <= rpcb_pkg::RPCB_HELD;
      st_q.start <= 1'h0;
      st_q.pc    <= `RPCB_BOOT_ADDR;
      st_q.hpi   <= '0;
      st_q.rdata <= `RPCB_RDATA_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  //////////////////////////////////////////////////////////////////////////

  assign reg_rdata_o = st_q.rdata;
  assign boot_pc_o   = st_q.pc;
  assign cpu_start_o = st_q.start;
  assign host_cfg_o  = st_q.hpi;
  assign cap_lo_o    = cap_lo;
  assign cap_hi_o    = cap_hi;

  //////////////////////////////////////////////////////////////////////////
  // checks
  //////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  // core is released from rom zero, after a held phase
  property p_boot_rom;
    cpu_start_o |-> boot_pc_o == 32'h0000_0000 && !$past(in_reset);
  endproperty
  a_boot_rom: assert property (p_boot_rom)
    else $error("core released from a nonzero address");

  // other resets alone leave both captures untouched
  property p_other_reset_keeps;
    (emu_reset_i || wdt_reset_i) && !cap_load
      |=> $stable(cap_lo) && $stable(cap_hi);
  endproperty
  a_other_reset_keeps: assert property (p_other_reset_keeps)
    else $error("capture changed without external reset edge");

  // spi0 data and clock land in low bits 7..5
  property p_lo_spi0;
    cap_load |=> cap_lo[7:5] == {$past(pins_i.spi0_slave_out),
                                 $past(pins_i.spi0_slave_in),
                                 $past(pins_i.spi0_clock)};
  endproperty
  a_lo_spi0: assert property (p_lo_spi0)
    else $error("low bits 7..5 wrong after capture");

  // spi0 select and enable land in low bits 4..3
  property p_lo_spi0_ctl;
    cap_load ##1 1'b1 |-> cap_lo[4] == $past(pins_i.spi0_chip_select)
                        && cap_lo[3] == $past(pins_i.spi0_enable_pin);
  endproperty
  a_lo_spi0_ctl: assert property (p_lo_spi0_ctl)
    else $error("low bits 4..3 wrong after capture");

  // spi1 data and clock land in low bits 2..0
  property p_lo_spi1;
    cap_load |=> cap_lo[2:0] == {$past(pins_i.spi1_slave_out),
                                 $past(pins_i.spi1_slave_in),
                                 $past(pins_i.spi1_clock)};
  endproperty
  a_lo_spi1: assert property (p_lo_spi1)
    else $error("low bits 2..0 wrong after capture");

  // spi1 select and enable land in high bits 7..6
  property p_hi_spi1;
    cap_load |=> cap_hi[7:6] == {$past(pins_i.spi1_chip_select),
                                 $past(pins_i.spi1_enable_pin)};
  endproperty
  a_hi_spi1: assert property (p_hi_spi1)
    else $error("high bits 7..6 wrong after capture");

  // host pins land in high bits 5..3
  property p_hi_host;
    cap_load |=> cap_hi[5:3] == {$past(pins_i.host_chip_select),
                                 $past(pins_i.host_data0),
                                 $past(pins_i.emif_d16_host_a0)};
  endproperty
  a_hi_host: assert property (p_hi_host)
    else $error("high bits 5..3 wrong after capture");

  // audio pins land in high bits 2..0
  property p_hi_audio;
    cap_load |=> cap_hi[2:0] == {$past(pins_i.audio_tx_frame_sync),
                                 $past(pins_i.audio_rx_frame_sync),
                                 $past(pins_i.audio_serializer_data)};
  endproperty
  a_hi_audio: assert property (p_hi_audio)
    else $error("high bits 2..0 wrong after capture");

  // a read of either capture gives zero reserved bits and the contents
  property p_read_rsvd;
    reg_req_i.rd && (hit_lo || hit_hi) |=>
      reg_rdata_o[31:8] == 24'h00_0000 &&
      reg_rdata_o[7:0] == ($past(hit_lo) ? $past(cap_lo) : $past(cap_hi));
  endproperty
  a_read_rsvd: assert property (p_read_rsvd)
    else $error("capture read returned wrong data");

  // host select low copies the spi0 levels into host config
  property p_host_cfg;
    cap_load && !pins_i.host_chip_select |=>
      host_cfg_o == {$past(pins_i.spi0_slave_out),
                     $past(pins_i.spi0_slave_in),
                     $past(pins_i.spi0_clock)};
  endproperty
  a_host_cfg: assert property (p_host_cfg)
    else $error("host config not copied from straps");

  // host select high keeps the host config
  property p_host_cfg_keep;
    !(cap_load && !pins_i.host_chip_select) |=> $stable(host_cfg_o);
  endproperty
  a_host_cfg_keep: assert property (p_host_cfg_keep)
    else $error("host config changed without host strap");

  // software writes never alter the captures
  property p_write_ro;
    reg_req_i.wr && (hit_lo || hit_hi) && !cap_load
      |=> $stable(cap_lo) && $stable(cap_hi);
  endproperty
  a_write_ro: assert property (p_write_ro)
    else $error("write altered a capture register");

  //////////////////////////////////////////////////////////////////////////
  // checks on core release, capture hold and idle read data
  //////////////////////////////////////////////////////////////////////////

  // the start pulse lasts exactly one cycle
  property p_start_pulse;
    cpu_start_o |=> !cpu_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("core release pulse longer than one cycle");

  // no release while any reset source is active
  property p_held_no_start;
    in_reset |=> !cpu_start_o;
  endproperty
  a_held_no_start: assert property (p_held_no_start)
    else $error("core released while a reset is active");

  // the last reset source going away releases the core
  property p_release_start;
    $fell(in_reset) |=> cpu_start_o;
  endproperty
  a_release_start: assert property (p_release_start)
    else $error("core not released after reset went away");

  // without a pin release both captures hold
  property p_cap_hold;
    !cap_load |=> $stable(cap_lo) && $stable(cap_hi);
  endproperty
  a_cap_hold: assert property (p_cap_hold)
    else $error("capture changed without a pin release");

  // read data is zero outside the cycle after a read
  property p_rdata_idle;
    !reg_req_i.rd |=> reg_rdata_o == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data present without a read");

  // a read outside both captures returns zero
  property p_unmapped_zero;
    reg_req_i.rd && !hit_lo && !hit_hi |=> reg_rdata_o == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read returned nonzero data");

endmodule : rpcb_top

// ==== rpcb_strap_model.sv ====
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// board strapping: resistors hold every boot pin at a fixed level
module rpcb_strap_model (
  input  wire logic                 use_mode_i,  // strap a boot mode on top
  input  wire logic [2:0]           mode_i,      // {out, in, clock} mode code
  input  wire logic [15:0]          free_i,      // levels of the other pins
  output rpcb_pkg::rpcb_pins_s      pins_o       // pin levels seen by the chip
);
  // resistors always drive, so no pin is ever left floating
  always_comb begin
    pins_o = rpcb_pkg::rpcb_pins_s'(free_i);
    // a strapped mode pulls host select high and sets the three spi0 pins
    if (use_mode_i) begin
      pins_o.host_chip_select = 1'b1;
      pins_o.spi0_slave_out   = mode_i[2];
      pins_o.spi0_slave_in    = mode_i[1];
      pins_o.spi0_clock       = mode_i[0];
    end
  end
endmodule : rpcb_strap_model

// ==== rpcb_top_bench.sv ====
`timescale 1ns/10ps
`include "rpcb_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// self-checking bench for the reset pin capture block
module rpcb_top_bench;
  logic                    core_clk_i    = 1'b0;   // 250 MHz clock
  logic                    reset_i       = 1'b1;   // block reset
  logic                    ext_reset_n_i = 1'b0;   // external reset pin
  logic                    emu_reset_i   = 1'b0;   // emulator reset
  logic                    wdt_reset_i   = 1'b0;   // watchdog reset
  logic                    use_mode      = 1'b0;   // strap a boot mode
  logic [2:0]              mode          = 3'h0;   // strapped mode code
  logic [15:0]             free_pins     = 16'h0000; // random pin levels
  rpcb_pkg::rpcb_pins_s    pins;                   // pins from the board
  rpcb_pkg::rpcb_bus_req_s req           = '0;     // register request
  logic [31:0]             rdata;                  // read data
  logic [31:0]             boot_pc;                // core start address
  logic                    cpu_start;              // core release pulse
  rpcb_pkg::rpcb_hpi_cfg_s host_cfg;               // host-port config
  logic [7:0]              cap_lo;                 // capture low
  logic [7:0]              cap_hi;                 // capture high
  int                      error_cnt  = 0;         // mismatches
  int                      num_checks = 0;         // comparisons
  int                      start_cnt  = 0;         // start pulses seen
  int                      s_base     = 0;         // pulses before a restart
  integer                  seed       = 32'hf9228833; // fixed seed
  logic [7:0]              lo_exp     = 8'h00;     // expected low capture
  logic [7:0]              hi_exp     = 8'h00;     // expected high capture
  logic [2:0]              hcfg_exp   = 3'h0;      // expected host config
  logic [31:0]             rd_val;                 // last read value
  logic [2:0]              modes [5]  = '{3'h2, 3'h1, 3'h3, 3'h5, 3'h7};

  always #2 core_clk_i = ~core_clk_i;

  rpcb_strap_model strap_u (.use_mode_i(use_mode), .mode_i(mode), .free_i(free_pins),
                            .pins_o(pins));

  rpcb_top dut_u (.core_clk_i(core_clk_i), .reset_i(reset_i), .ext_reset_n_i(ext_reset_n_i),
                  .emu_reset_i(emu_reset_i), .wdt_reset_i(wdt_reset_i), .pins_i(pins),
                  .reg_req_i(req), .reg_rdata_o(rdata), .boot_pc_o(boot_pc),
                  .cpu_start_o(cpu_start), .host_cfg_o(host_cfg), .cap_lo_o(cap_lo),
                  .cap_hi_o(cap_hi));

  // count core release pulses
  always @(posedge core_clk_i) begin
    if (cpu_start === 1'b1) begin
      start_cnt++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // expected field layout of the two capture registers
  function automatic logic [7:0] exp_lo(input rpcb_pkg::rpcb_pins_s p);
    return {p.spi0_slave_out, p.spi0_slave_in, p.spi0_clock, p.spi0_chip_select,
            p.spi0_enable_pin, p.spi1_slave_out, p.spi1_slave_in, p.spi1_clock};
  endfunction : exp_lo

  function automatic logic [7:0] exp_hi(input rpcb_pkg::rpcb_pins_s p);
    return {p.spi1_chip_select, p.spi1_enable_pin, p.host_chip_select, p.host_data0,
            p.emif_d16_host_a0, p.audio_tx_frame_sync, p.audio_rx_frame_sync,
            p.audio_serializer_data};
  endfunction : exp_hi

  // single compare task, case equality so unknowns fail
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge core_clk_i);
    req.wr    <= 1'b0;
  endtask : wr

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge core_clk_i);
    req.rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  // read both capture registers against the expected values
  task automatic read_caps();
    rd(`RPCB_CAP_LO_ADDR, rd_val);
    chk(rd_val, {`RPCB_RSVD_ZERO, lo_exp}, "read low");
    rd(`RPCB_CAP_HI_ADDR, rd_val);
    chk(rd_val, {`RPCB_RSVD_ZERO, hi_exp}, "read high");
  endtask : read_caps

  // pulse the external reset pin with given straps and check the capture
  task automatic capture(input logic [15:0] raw, input logic um, input logic [2:0] md);
    int s0;
    @(posedge core_clk_i);
    ext_reset_n_i <= 1'b0;
    free_pins     <= raw;
    use_mode      <= um;
    mode          <= md;
    s0 = start_cnt;
    @(posedge core_clk_i);
    ext_reset_n_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    lo_exp = exp_lo(pins);
    hi_exp = exp_hi(pins);
    if (pins.host_chip_select === 1'b0) begin
      hcfg_exp = {pins.spi0_slave_out, pins.spi0_slave_in, pins.spi0_clock};
    end
    chk(cap_lo, lo_exp, "capture low");
    chk(cap_hi, hi_exp, "capture high");
    chk(host_cfg, hcfg_exp, "host config");
    chk(boot_pc, `RPCB_BOOT_ADDR, "boot address");
    repeat (2) @(posedge core_clk_i);
    chk(start_cnt - s0, 1, "start pulses");
    read_caps();
  endtask : capture

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge core_clk_i);
    reset_i <= 1'b0;
    // every strapped boot mode
    foreach (modes[i]) begin
      capture($random(seed), 1'b1, modes[i]);
    end
    $display("test boot modes done");
    // host-port boot with every config combination
    for (int i = 0; i < 8; i++) begin
      rd_val = $random(seed);
      capture({i[2:0], rd_val[12:6], 1'b0, rd_val[4:0]}, 1'b0, 3'h0);
    end
    $display("test host config done");
    repeat (20) capture($random(seed), 1'b0, 3'h0);
    $display("test random straps done");
    // emulator and watchdog resets must not recapture
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk_i);
      s_base = start_cnt;
      free_pins   <= ~free_pins;
      emu_reset_i <= (k == 0);
      wdt_reset_i <= (k == 1);
      repeat (3) @(posedge core_clk_i);
      emu_reset_i <= 1'b0;
      wdt_reset_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      #1;
      chk(cap_lo, lo_exp, "no recapture low");
      chk(cap_hi, hi_exp, "no recapture high");
      chk(host_cfg, hcfg_exp, "no host reload");
      chk(start_cnt - s_base, 1, "restart pulse");
    end
    $display("test other resets done");
    // writes to both captures, one idle cycle apart, are ignored; unmapped read gives idle
    wr(`RPCB_CAP_LO_ADDR, {24'h00_0000, ~lo_exp});
    wr(`RPCB_CAP_HI_ADDR, {24'h00_0000, ~hi_exp});
    read_caps();
    rd(32'h4000_0008, rd_val);
    chk(rd_val, `RPCB_RDATA_IDLE, "unmapped read");
    $display("test writes done");
    summarize();
  end

  // cut a hang short
  initial begin
    #20000;
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end

  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
endmodule : rpcb_top_bench
